// file: scc_defs.svh
// Constants for the standby and conversion control block.
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH
`define SCC_CLK_HZ         20000000
`define SCC_CONV_MS        125
`define SCC_CONV_CYC       ((`SCC_CLK_HZ / 1000) * `SCC_CONV_MS)
`define SCC_RATE_CYC_DEF   20000000
`define SCC_OFF_CTRL       12'h000
`define SCC_OFF_STAT       12'h004
`define SCC_OFF_RATE       12'h008
`define SCC_OFF_RES        12'h00c
`define SCC_OFF_ADC        12'h010
`define SCC_CTRL_HALT_BIT  0
`define SCC_CTRL_SHOT_BIT  1
`define SCC_CTRL_RST       32'h0000_0000
`define SCC_STAT_BUSY_BIT  0
`define SCC_STAT_HWSB_BIT  1
`define SCC_STAT_SWSB_BIT  2
`define SCC_STAT_ABRT_BIT  3
`define SCC_RESP_OKAY      2'b00
`define SCC_RESP_SLVERR    2'b10
`endif

// file: scc_pkg.sv
// Types for the standby and conversion control block.
package scc_pkg;
  typedef enum logic [3:0] {
    SCC_IDLE  = 4'b0001,
    SCC_REM   = 4'b0010,
    SCC_LOC   = 4'b0100,
    SCC_LATCH = 4'b1000
  } scc_state_t;
  typedef struct packed {
    logic [7:0] remote;
    logic [7:0] local_t;
  } scc_result_t;
endpackage : scc_pkg

// file: scc_sync.sv
// Two flip-flop synchroniser for a pin input.
`timescale 1ns/1ps
module scc_sync
  import scc_pkg::*;
#(
  parameter logic RST_VAL = 1'b1
)
(
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta_r;
  logic meta_nxt;
  logic q_r;
  logic q_nxt;

  always_comb
  begin
    meta_nxt = rstn_i ? d_i : RST_VAL;
    q_nxt    = rstn_i ? meta_r : RST_VAL;
  end

  always_ff @(posedge clk_i)
  begin
    meta_r <= meta_nxt;
    q_r    <= q_nxt;
  end

  assign q_o = q_r;
endmodule : scc_sync

// file: scc_ctrl.sv
// Standby and conversion sequencing with an AXI4-Lite register slave.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "scc_defs.svh"
module scc_ctrl
  import scc_pkg::*;
#(
  parameter int unsigned CONV_CYC     = `SCC_CONV_CYC,
  parameter int unsigned RATE_CYC_DEF = `SCC_RATE_CYC_DEF
)
(
  input  wire logic        MCLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        HW_SLEEP_PIN_I,
  input  wire logic [7:0]  ADC_DATA_I,
  output logic             ADC_EN_O,
  output logic             ADC_SEL_REMOTE_O,
  output logic             BUSY_O,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [11:0] S_AXI_AWADDR,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  output logic [1:0]       S_AXI_BRESP,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  input  wire logic [11:0] S_AXI_ARADDR,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP
);
  localparam int unsigned HALF_CYC = CONV_CYC / 2;

  logic        pin_s;
  scc_state_t  st_r,      st_nxt;
  logic [31:0] cnt_r,     cnt_nxt;
  logic [31:0] rate_r,    rate_nxt;
  logic [31:0] tmr_r,     tmr_nxt;
  logic        halt_r,    halt_nxt;
  logic        shot_r,    shot_nxt;
  logic        abrt_r,    abrt_nxt;
  logic [7:0]  rem_r,     rem_nxt;
  scc_result_t res_r,     res_nxt;
  logic        aw_r,      aw_nxt;
  logic [11:0] awa_r,     awa_nxt;
  logic        w_r,       w_nxt;
  logic [31:0] wd_r,      wd_nxt;
  logic        bv_r,      bv_nxt;
  logic [1:0]  br_r,      br_nxt;
  logic        rv_r,      rv_nxt;
  logic [31:0] rd_r,      rd_nxt;
  logic [1:0]  rr_r,      rr_nxt;
  logic        do_wr;
  logic        hw_sb;
  logic        sb;
  logic        shot_set;
  logic        start;
  logic        sw_shot_r, sw_shot_nxt;
  logic        ws0_r,     ws0_nxt;

  scc_sync #(
    .RST_VAL (1'b1)
  ) u_pin_sync (
    .clk_i  (MCLK_I),
    .rstn_i (RESETN_I),
    .d_i    (HW_SLEEP_PIN_I),
    .q_o    (pin_s)
  );

  always_comb
  begin
    hw_sb    = ~pin_s;
    sb       = hw_sb | halt_r;
    do_wr    = aw_r & w_r & ~bv_r;
    shot_set = do_wr & (awa_r == `SCC_OFF_CTRL) & ws0_r
               & wd_r[`SCC_CTRL_SHOT_BIT];
    start    = 1'b0;
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    tmr_nxt  = tmr_r;
    shot_nxt = shot_r;
    abrt_nxt = abrt_r;
    rem_nxt  = rem_r;
    res_nxt  = res_r;
    if (hw_sb)
    begin
      shot_nxt = 1'b0;
    end
    else if (shot_set)
    begin
      shot_nxt = 1'b1;
    end
    if (sb || tmr_r == 32'h0)
    begin
      tmr_nxt = (rate_r == 32'h0) ? 32'h0 : rate_r - 32'h1;
    end
    else
    begin
      tmr_nxt = tmr_r - 32'h1;
    end
    unique case (st_r)
      SCC_IDLE:
      begin
        if (!hw_sb && (shot_r || (!halt_r && tmr_r == 32'h0)))
        begin
          start    = 1'b1;
          shot_nxt = shot_set;
          st_nxt   = SCC_REM;
          cnt_nxt  = 32'h0;
        end
      end
      SCC_REM, SCC_LOC:
      begin
        cnt_nxt = cnt_r + 32'h1;
        if (st_r == SCC_REM && cnt_r == HALF_CYC - 1)
        begin
          rem_nxt = ADC_DATA_I;
          st_nxt  = SCC_LOC;
        end
        if (st_r == SCC_LOC && cnt_r == CONV_CYC - 1)
        begin
          res_nxt.remote  = rem_r;
          res_nxt.local_t = ADC_DATA_I;
          st_nxt          = SCC_LATCH;
        end
      end
      SCC_LATCH:
      begin
        st_nxt = SCC_IDLE;
      end
      default:
      begin
        st_nxt = SCC_IDLE;
      end
    endcase
    if (start)
    begin
      abrt_nxt = 1'b0;
    end
    if ((st_r == SCC_REM || st_r == SCC_LOC) && (hw_sb || (halt_r && !sw_shot_r)))
    begin
      st_nxt   = SCC_IDLE;
      res_nxt  = res_r;
      abrt_nxt = 1'b1;
    end
  end

  always_comb
  begin
    sw_shot_nxt = sw_shot_r;
    if (start)
    begin
      sw_shot_nxt = halt_r;
    end
    else if (st_r == SCC_IDLE)
    begin
      sw_shot_nxt = 1'b0;
    end
  end

  always_comb
  begin
    aw_nxt   = aw_r;
    awa_nxt  = awa_r;
    w_nxt    = w_r;
    wd_nxt   = wd_r;
    ws0_nxt  = ws0_r;
    bv_nxt   = bv_r;
    br_nxt   = br_r;
    halt_nxt = halt_r;
    rate_nxt = rate_r;
    rv_nxt   = rv_r;
    rd_nxt   = rd_r;
    rr_nxt   = rr_r;
    if (S_AXI_AWVALID && !aw_r && !bv_r)
    begin
      aw_nxt  = 1'b1;
      awa_nxt = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !w_r && !bv_r)
    begin
      w_nxt  = 1'b1;
      wd_nxt  = S_AXI_WDATA;
      ws0_nxt = S_AXI_WSTRB[0];
    end
    if (do_wr)
    begin
      aw_nxt = 1'b0;
      w_nxt  = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = `SCC_RESP_OKAY;
      unique case (awa_r)
        `SCC_OFF_CTRL:
        begin
          if (ws0_r)
          begin
            halt_nxt = wd_r[`SCC_CTRL_HALT_BIT];
          end
        end
        `SCC_OFF_RATE:
        begin
          rate_nxt = wd_r;
        end
        `SCC_OFF_STAT, `SCC_OFF_RES, `SCC_OFF_ADC:
        begin
          br_nxt = `SCC_RESP_OKAY;
        end
        default:
        begin
          br_nxt = `SCC_RESP_SLVERR;
        end
      endcase
    end
    else if (bv_r && S_AXI_BREADY)
    begin
      bv_nxt = 1'b0;
    end
    if (S_AXI_ARVALID && !rv_r)
    begin
      rv_nxt = 1'b1;
      rr_nxt = `SCC_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        `SCC_OFF_CTRL: rd_nxt = {30'h0, shot_r, halt_r};
        `SCC_OFF_STAT: rd_nxt = {28'h0, abrt_r, halt_r, hw_sb, st_r != SCC_IDLE};
        `SCC_OFF_RATE: rd_nxt = rate_r;
        `SCC_OFF_RES:  rd_nxt = {16'h0, res_r};
        `SCC_OFF_ADC:  rd_nxt = {24'h0, rem_r};
        default:
        begin
          rd_nxt = 32'h0;
          rr_nxt = `SCC_RESP_SLVERR;
        end
      endcase
    end
    else if (rv_r && S_AXI_RREADY)
    begin
      rv_nxt = 1'b0;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      st_r      <= SCC_IDLE;
      cnt_r     <= 32'h0;
      rate_r    <= RATE_CYC_DEF;
      tmr_r     <= 32'h0;
      halt_r    <= 1'b0;
      shot_r    <= 1'b0;
      sw_shot_r <= 1'b0;
      abrt_r    <= 1'b0;
      rem_r     <= 8'h00;
      res_r     <= '0;
      aw_r      <= 1'b0;
      awa_r     <= 12'h000;
      w_r       <= 1'b0;
      wd_r      <= 32'h0;
      ws0_r     <= 1'b0;
      bv_r      <= 1'b0;
      br_r      <= 2'b00;
      rv_r      <= 1'b0;
      rd_r      <= 32'h0;
      rr_r      <= 2'b00;
    end
    else
    begin
      st_r      <= st_nxt;
      cnt_r     <= cnt_nxt;
      rate_r    <= rate_nxt;
      tmr_r     <= tmr_nxt;
      halt_r    <= halt_nxt;
      shot_r    <= shot_nxt;
      sw_shot_r <= sw_shot_nxt;
      abrt_r    <= abrt_nxt;
      rem_r     <= rem_nxt;
      res_r     <= res_nxt;
      aw_r      <= aw_nxt;
      awa_r     <= awa_nxt;
      w_r       <= w_nxt;
      wd_r      <= wd_nxt;
      ws0_r     <= ws0_nxt;
      bv_r      <= bv_nxt;
      br_r      <= br_nxt;
      rv_r      <= rv_nxt;
      rd_r      <= rd_nxt;
      rr_r      <= rr_nxt;
    end
  end

  logic adc_en_r;
  logic sel_r;
  logic busy_r;

  always_ff @(posedge MCLK_I)
  begin
    if (!RESETN_I)
    begin
      adc_en_r <= 1'b0;
      sel_r    <= 1'b0;
      busy_r   <= 1'b0;
    end
    else
    begin
      adc_en_r <= (st_nxt == SCC_REM) || (st_nxt == SCC_LOC);
      sel_r    <= (st_nxt == SCC_REM);
      busy_r   <= (st_nxt != SCC_IDLE);
    end
  end

  assign ADC_EN_O         = adc_en_r;
  assign ADC_SEL_REMOTE_O = sel_r;
  assign BUSY_O           = busy_r;
  assign S_AXI_AWREADY    = ~aw_r & ~bv_r;
  assign S_AXI_WREADY     = ~w_r & ~bv_r;
  assign S_AXI_BVALID     = bv_r;
  assign S_AXI_BRESP      = br_r;
  assign S_AXI_ARREADY    = ~rv_r;
  assign S_AXI_RVALID     = rv_r;
  assign S_AXI_RDATA      = rd_r;
  assign S_AXI_RRESP      = rr_r;
endmodule : scc_ctrl

// file: scc_adc_model.sv
// Converter front-end model that answers each channel with a set code.
`timescale 1ns/1ps
module scc_adc_model
  import scc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       en_i,
  input  wire logic       sel_i,
  input  wire logic [7:0] rem_i,
  input  wire logic [7:0] loc_i,
  output logic      [7:0] data_o
);
  logic [7:0] last_r = 8'h00;
  // When idle the bus shows a pattern that changes every cycle.
  assign data_o = en_i ? (sel_i ? rem_i : loc_i) : ~last_r;
  always @(posedge clk_i)
  begin
    last_r <= data_o;
  end
endmodule : scc_adc_model

// file: scc_ctrl_checker.sv
// Assertion checker for the standby and conversion control block.
`timescale 1ns/1ps
module scc_ctrl_checker
  import scc_pkg::*;
#(
  parameter int unsigned CONV_CYC = 20
)
(
  input wire logic        MCLK_I,
  input wire logic        RESETN_I,
  input wire logic        HW_SLEEP_PIN_I,
  input wire logic        ADC_EN_O,
  input wire logic        ADC_SEL_REMOTE_O,
  input wire logic        BUSY_O,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [11:0] S_AXI_ARADDR,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [1:0]  S_AXI_RRESP
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  int unsigned en_cnt_r;
  int unsigned en_cnt_nxt;
  always_comb en_cnt_nxt = ADC_EN_O ? en_cnt_r + 1 : 0;
  always_ff @(posedge MCLK_I)
  begin
    en_cnt_r <= RESETN_I ? en_cnt_nxt : 0;
  end
  chk_pin_no_conv: assert property (!HW_SLEEP_PIN_I [*6] |-> !ADC_EN_O)
    else $error("converter on while sleep pin low");
  chk_pin_abort: assert property ($fell(HW_SLEEP_PIN_I) |-> ##[1:5] !BUSY_O)
    else $error("conversion not aborted by sleep pin");
  chk_en_busy: assert property (ADC_EN_O |-> BUSY_O)
    else $error("converter on without busy");
  chk_remote_first: assert property ($rose(ADC_EN_O) |-> ADC_SEL_REMOTE_O [*8])
    else $error("remote half missing");
  chk_sel_en: assert property (ADC_SEL_REMOTE_O |-> ADC_EN_O)
    else $error("remote select outside conversion");
  chk_conv_len: assert property (en_cnt_r <= CONV_CYC)
    else $error("conversion too long");
  chk_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped");
  chk_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> $stable(S_AXI_RRESP))
    else $error("read response changed");
  chk_bad_addr: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 12'hffc
    |=> S_AXI_RVALID && S_AXI_RRESP == 2'b10)
    else $error("unmapped read not refused");
endmodule : scc_ctrl_checker
bind scc_ctrl scc_ctrl_checker #(.CONV_CYC(CONV_CYC)) u_chk (.MCLK_I, .RESETN_I,
  .HW_SLEEP_PIN_I, .ADC_EN_O, .ADC_SEL_REMOTE_O, .BUSY_O, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_ARADDR, .S_AXI_RVALID, .S_AXI_RREADY,
  .S_AXI_RRESP);

// file: scc_ctrl_tb.sv
// Self-checking testbench for the standby and conversion control block.
`timescale 1ns/1ps
`include "scc_defs.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end
module scc_ctrl_tb
  import scc_pkg::*;
;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [1:0] r;} scc_row_t;
  logic clk = 0, rst_n = 0, pin = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
  logic awr, wr, bv, arr, rv, en, sel, busy;
  logic [11:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, rd, d;
  logic [3:0] ws = 4'hf;
  logic [1:0] bresp, rresp, r;
  logic [7:0] adc, rem = 8'h5a, loc = 8'h3c;
  int bad_count = 0, checked = 0;
  scc_row_t rows [4] = '{'{`SCC_OFF_CTRL, 0, 0}, '{`SCC_OFF_RATE, 32'h64, 0},
    '{`SCC_OFF_RES, 0, 0}, '{12'hffc, 0, `SCC_RESP_SLVERR}};
  always #25 clk = ~clk;
  scc_ctrl #(.CONV_CYC(20), .RATE_CYC_DEF(100)) DUT (.MCLK_I(clk), .RESETN_I(rst_n),
    .HW_SLEEP_PIN_I(pin), .ADC_DATA_I(adc), .ADC_EN_O(en), .ADC_SEL_REMOTE_O(sel),
    .BUSY_O(busy), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(br), .S_AXI_BRESP(bresp), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp));
  scc_adc_model u_adc (.clk_i(clk), .en_i(en), .sel_i(sel), .rem_i(rem), .loc_i(loc),
    .data_o(adc));
  task automatic final_report;
    if (bad_count == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic tmo;
    bad_count++;
    final_report();
  endtask : tmo
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    @(posedge clk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    repeat (50)
    begin
      @(negedge clk);
      ta = awv && awr;
      tw = wv && wr;
      tb = bv;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb)
      begin
        br <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : axw
  task automatic axr(input logic [11:0] a);
    logic ta, tr;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    repeat (50)
    begin
      @(negedge clk);
      ta = arv && arr;
      tr = rv;
      d = rd;
      r = rresp;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tr)
      begin
        rr <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : axr
  task automatic wait_busy(input logic v);
    repeat (400)
    begin
      @(negedge clk);
      if (busy === v) return;
    end
    tmo();
  endtask : wait_busy
  task automatic quiet(input int n);
    repeat (n)
    begin
      @(negedge clk);
      `CHK(busy, 1'b0)
    end
  endtask : quiet
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      axr(rows[i].a);
      `CHK(d, rows[i].d)
      `CHK(r, rows[i].r)
    end
    wait_busy(1);
    wait_busy(0);
    axr(`SCC_OFF_RES);
    `CHK(d, 32'h5a3c)
    wait_busy(1);
    wait_busy(0);
    axw(`SCC_OFF_CTRL, 32'h1);
    quiet(150);
    axr(`SCC_OFF_STAT);
    `CHK(d[2], 1'b1)
    rem <= 8'h11;
    loc <= 8'h22;
    axw(`SCC_OFF_CTRL, 32'h3);
    wait_busy(1);
    wait_busy(0);
    axr(`SCC_OFF_RES);
    `CHK(d, 32'h1122)
    quiet(150);
    pin <= 1'b0;
    axw(`SCC_OFF_CTRL, 32'h3);
    quiet(150);
    axr(`SCC_OFF_STAT);
    `CHK(d[1], 1'b1)
    axr(`SCC_OFF_RES);
    `CHK(d, 32'h1122)
    pin <= 1'b1;
    rem <= 8'h77;
    loc <= 8'h66;
    axw(`SCC_OFF_CTRL, 32'h0);
    wait_busy(1);
    repeat (12) @(posedge clk);
    pin <= 1'b0;
    wait_busy(0);
    axr(`SCC_OFF_RES);
    `CHK(d, 32'h1122)
    axr(`SCC_OFF_STAT);
    `CHK(d[3], 1'b1)
    final_report();
  end
endmodule : scc_ctrl_tb
